// ---- rtl/lpm_ctrl.sv ----
// low-power mode controller: entry, wake qualification, regulator and pad control
//
// Contract
// - wait mode stops the processor clock, peripheral clocks keep running
// - wait resumes on internal interrupt, external interrupt or reset
// - both active-halt variants gate processor and all peripheral clocks
// - periodic wake timer raises internal wakeup after programmed interval
// - active-halt regulator-on keeps regulator, wakes on timer, external irq, reset
// - active-halt regulator-off switches regulator off, slower wakeup
// - halt stops all clocks, regulator off, wakes on external event or reset
// - power, ram retention and brownout detection stay on in every mode
// - crystal input pad paths disabled in halt and active-halt
// - in halt and active-halt pad pull-up off if crystal clock wakes, else follows option bit; off in run and wait
`timescale 1ns/1ps
`include "lpm_regs.svh"
module lpm_ctrl (
    input wire logic CLK, // system clock
    input wire logic RSTN, // async reset, active low
    input wire logic ENTER_REQ, // one-cycle entry request from processor
    input wire lpm_pkg::lpm_mode_t MODE_SEL, // requested mode
    input wire logic REG_ON_SEL, // keep regulator on in active-halt
    input wire logic [15:0] WAKE_INTERVAL, // wake timer interval in cycles
    input wire logic INT_IRQ, // internal interrupt
    input wire logic EXT_IRQ, // external interrupt or event
    input wire logic RESET_SRC, // reset source request
    input wire logic XTAL_WAKE, // crystal clock used as wake clock
    input wire logic PULLUP_OPT, // pad pull-up option bit
    output logic CPU_CLK_EN, // processor clock enable
    output logic PERIPH_CLK_EN, // peripheral clock enable
    output logic REG_EN, // main regulator enable
    output logic CPU_RELEASE, // one-cycle resume pulse
    output logic SYS_RESET_REQ, // reset path request pulse
    output logic PAD_PATH_EN, // crystal input pad io path enable
    output logic PAD_PULLUP_EN, // crystal input pad pull-up
    output logic POWER_KEEP, // processor, ram and brownout kept on
    output logic [2:0] STATE // current state
);
    import lpm_pkg::*;
    lpm_state_t state_q, state_d;
    logic reg_keep_q;
    logic [15:0] tmr_q;
    logic [15:0] interval_q;
    logic [7:0] settle_q;
    logic tmr_wake;
    logic wake_any;
    logic keep_sel;
    // ------------------------------
    // wake timer
    // ------------------------------
    assign tmr_wake = (state_q == LPM_AHALT) && (tmr_q >= interval_q);
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tmr_q <= 16'h0000;
        end else if (state_q == LPM_AHALT) begin
            tmr_q <= tmr_q + 16'h0001;
        end else begin
            // preload one so the first halted cycle already counts
            tmr_q <= 16'h0001;
        end
    end
    // ------------------------------
    // entry latch
    // ------------------------------
    // choices are taken only in run, so a strobe while halted cannot change them
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            reg_keep_q <= 1'b1;
            interval_q <= `LPM_WAKE_INTERVAL_RST;
        end else if (state_q == LPM_RUN && ENTER_REQ) begin
            reg_keep_q <= REG_ON_SEL;
            // a zero interval would sit below the preloaded count of one, so it is raised to one
            interval_q <= (WAKE_INTERVAL == 16'h0000) ? 16'h0001 : WAKE_INTERVAL;
        end
    end
    // regulator choice: live select on the entry edge, latched copy afterwards
    assign keep_sel = (state_q == LPM_RUN) ? REG_ON_SEL : reg_keep_q;
    // ------------------------------
    // mode state machine
    // ------------------------------
    always_comb begin
        state_d = state_q;
        wake_any = 1'b0;
        case (state_q)
            LPM_RUN: begin
                if (ENTER_REQ && !RESET_SRC) begin
                    case (MODE_SEL)
                        `LPM_MODE_WAIT: state_d = LPM_WAIT;
                        `LPM_MODE_AHALT: state_d = LPM_AHALT;
                        `LPM_MODE_HALT: state_d = LPM_HALT;
                        default: state_d = LPM_RUN;
                    endcase
                end
            end
            LPM_WAIT: begin
                wake_any = INT_IRQ || EXT_IRQ;
            end
            LPM_AHALT: begin
                wake_any = tmr_wake || EXT_IRQ;
            end
            LPM_HALT: begin
                wake_any = EXT_IRQ;
            end
            LPM_SETTLE: begin
                if (settle_q == 8'h00) begin
                    state_d = LPM_RUN;
                end
            end
            default: state_d = LPM_RUN;
        endcase
        if (wake_any) begin
            // regulator off needs settle time first
            state_d = (state_q == LPM_WAIT || (state_q == LPM_AHALT && reg_keep_q)) ?
                LPM_RUN : LPM_SETTLE;
        end
        if (RESET_SRC) begin
            state_d = LPM_RUN;
        end
    end
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= LPM_RUN;
        end else begin
            state_q <= state_d;
        end
    end
    // settle counter for regulator restart
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            settle_q <= 8'h00;
        end else if (state_q != LPM_SETTLE) begin
            settle_q <= 8'(`LPM_REG_SETTLE_CYC - 1);
        end else if (settle_q != 8'h00) begin
            settle_q <= settle_q - 8'h01;
        end
    end
    // ------------------------------
    // registered outputs
    // ------------------------------
    // outputs follow the next state, so pins move on the edge that takes a request
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            CPU_CLK_EN <= 1'b1;
            PERIPH_CLK_EN <= 1'b1;
            REG_EN <= 1'b1;
            CPU_RELEASE <= 1'b0;
            SYS_RESET_REQ <= 1'b0;
            PAD_PATH_EN <= 1'b1;
            PAD_PULLUP_EN <= 1'b0;
            POWER_KEEP <= 1'b1;
            STATE <= 3'h0;
        end else begin
            CPU_CLK_EN <= (state_d == LPM_RUN);
            PERIPH_CLK_EN <= (state_d == LPM_RUN) || (state_d == LPM_WAIT);
            REG_EN <= !(state_d == LPM_HALT
                || (state_d == LPM_AHALT && !keep_sel));
            CPU_RELEASE <= (state_q != LPM_RUN) && (state_d == LPM_RUN) && !RESET_SRC;
            SYS_RESET_REQ <= RESET_SRC;
            PAD_PATH_EN <= !(state_d == LPM_AHALT || state_d == LPM_HALT);
            PAD_PULLUP_EN <= (state_d == LPM_AHALT || state_d == LPM_HALT) ?
                (!XTAL_WAKE && PULLUP_OPT) : 1'b0;
            POWER_KEEP <= 1'b1;
            STATE <= 3'(state_d);
        end
    end
    // ------------------------------
    // assertions
    // ------------------------------
    // checks watch the registered pins, the timer and the entry latch against the state flops, the next state and the inputs
    wait_clocks_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_WAIT && !INT_IRQ && !EXT_IRQ && !RESET_SRC) |=>
        (!CPU_CLK_EN && PERIPH_CLK_EN))
        else $error("wait mode clocks wrong");
    wait_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_WAIT && INT_IRQ && !RESET_SRC) |=> CPU_RELEASE && CPU_CLK_EN)
        else $error("wait did not resume on interrupt");
    ahalt_clocks_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_AHALT) |-> (!CPU_CLK_EN && !PERIPH_CLK_EN))
        else $error("active-halt clocks not gated");
    // the timer may never pass its interval, so a missed wake shows at once
    timer_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_AHALT) |-> (tmr_q <= interval_q))
        else $error("wake timer overran interval");
    timer_fire_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_AHALT && tmr_q >= interval_q) |=> (state_q != LPM_AHALT))
        else $error("wake timer did not end active-halt");
    ahalt_regon_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_AHALT && reg_keep_q && $past(state_q) == LPM_AHALT) |-> REG_EN)
        else $error("regulator dropped in active-halt");
    ahalt_regoff_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_AHALT && !reg_keep_q && state_d == LPM_AHALT) |=> !REG_EN)
        else $error("regulator on in regulator-off mode");
    halt_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_HALT && !EXT_IRQ && !RESET_SRC) |=> state_q == LPM_HALT && !REG_EN)
        else $error("halt left without external event");
    pad_path_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_HALT || state_q == LPM_AHALT) |-> !PAD_PATH_EN)
        else $error("pad path enabled in halt");
    pad_pull_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_d == LPM_HALT && XTAL_WAKE) |=> !PAD_PULLUP_EN)
        else $error("pull-up on with crystal wake");
    entry_latch_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_RUN && ENTER_REQ) |=> reg_keep_q == $past(REG_ON_SEL))
        else $error("regulator choice not latched");
    settle_done_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_SETTLE && !RESET_SRC) |-> ##[1:40] CPU_RELEASE)
        else $error("no release after settle");
    keep_power_a: assert property (@(posedge CLK) disable iff (!RSTN)
        POWER_KEEP)
        else $error("power keep dropped");
    release_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN)
        CPU_RELEASE |=> !CPU_RELEASE)
        else $error("resume pulse longer than one cycle");
    reset_path_a: assert property (@(posedge CLK) disable iff (!RSTN)
        RESET_SRC |=> (SYS_RESET_REQ && !CPU_RELEASE && STATE == 3'h0))
        else $error("reset source did not take reset path");
    regon_entry_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_q == LPM_RUN && ENTER_REQ && !RESET_SRC && MODE_SEL == `LPM_MODE_AHALT
        && REG_ON_SEL) |=> (REG_EN && STATE == 3'h2))
        else $error("regulator dropped on active-halt entry");
endmodule

// ---- rtl/lpm_regs.svh ----
// constants for the low-power mode controller
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH
`define LPM_MODE_WAIT 2'h0
`define LPM_MODE_AHALT 2'h1
`define LPM_MODE_HALT 2'h2
`define LPM_MODE_NONE 2'h3
`define LPM_WAKE_INTERVAL_RST 16'h0010
// regulator settle time in ns and derived cycles at 10 ns per cycle
`define LPM_REG_SETTLE_NS 200
`define LPM_REG_SETTLE_CYC ((`LPM_REG_SETTLE_NS + 9) / 10)
`endif

// ---- rtl/lpm_pkg.sv ----
// types for the low-power mode controller
package lpm_pkg;
    typedef logic [1:0] lpm_mode_t;
    typedef enum logic [2:0] {
        LPM_RUN,
        LPM_WAIT,
        LPM_AHALT,
        LPM_HALT,
        LPM_SETTLE
    } lpm_state_t;
endpackage

// ---- tb/lpm_cpu_model.sv ----
// processor core model for the low-power mode controller bench
`timescale 1ns/1ps
module lpm_cpu_model (
    input wire logic clk, // system clock
    input wire logic rstn, // reset, active low
    input wire logic release_in, // resume pulse
    output logic pullup_opt, // pad pull-up option
    output logic [7:0] resume_cnt // resumes seen
);
    // software keeps the pad from floating in halt states
    assign pullup_opt = 1'b1;
    // count resume pulses handed to the core
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resume_cnt <= 8'h00;
        end else if (release_in) begin
            resume_cnt <= resume_cnt + 8'h01;
        end
    end
endmodule

// ---- tb/low_power_mode_controller_bench.sv ----
// self-checking bench for the low-power mode controller
`timescale 1ns/1ps
module low_power_mode_controller_bench;
    import lpm_pkg::*;
    logic CLK = 0, RSTN = 0, ENTER_REQ = 0, REG_ON_SEL = 0, INT_IRQ = 0, EXT_IRQ = 0;
    logic RESET_SRC = 0, XTAL_WAKE = 0, PULLUP_OPT, CPU_CLK_EN, PERIPH_CLK_EN, REG_EN;
    logic CPU_RELEASE, SYS_RESET_REQ, PAD_PATH_EN, PAD_PULLUP_EN, POWER_KEEP;
    lpm_mode_t MODE_SEL = 2'h3;
    logic [15:0] WAKE_INTERVAL = 16'h0005;
    logic [2:0] STATE;
    logic [7:0] resume_cnt;
    int bad_count = 0, num_checks = 0, cyc = 0, n;
    // ----------------
    // design and core
    // ----------------
    lpm_ctrl uut (.CLK, .RSTN, .ENTER_REQ, .MODE_SEL, .REG_ON_SEL, .WAKE_INTERVAL,
        .INT_IRQ, .EXT_IRQ, .RESET_SRC, .XTAL_WAKE, .PULLUP_OPT, .CPU_CLK_EN,
        .PERIPH_CLK_EN, .REG_EN, .CPU_RELEASE, .SYS_RESET_REQ, .PAD_PATH_EN,
        .PAD_PULLUP_EN, .POWER_KEEP, .STATE);
    lpm_cpu_model cpu (.clk(CLK), .rstn(RSTN), .release_in(CPU_RELEASE),
        .pullup_opt(PULLUP_OPT), .resume_cnt(resume_cnt));
    // clock and hang guard
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            summarize();
        end
    end
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // request entry with a one-cycle strobe, sample after the taking edge
    task automatic enter(input lpm_mode_t m, input logic r);
        @(posedge CLK);
        ENTER_REQ <= 1'b1;
        MODE_SEL <= m;
        REG_ON_SEL <= r;
        @(posedge CLK);
        ENTER_REQ <= 1'b0;
        #1;
    endtask
    task automatic wait_rel(input int lim);
        n = 0;
        while (CPU_RELEASE !== 1'b1 && n < lim) begin
            @(posedge CLK);
            #1;
            n++;
        end
    endtask
    task automatic pulse_ext;
        @(posedge CLK);
        EXT_IRQ <= 1'b1;
        @(posedge CLK);
        EXT_IRQ <= 1'b0;
        #1;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task t_wait;
        enter(2'h0, 1'b0);
        chk({CPU_CLK_EN, PERIPH_CLK_EN, REG_EN, PAD_PATH_EN, POWER_KEEP, STATE}, 8'h79);
        @(posedge CLK);
        INT_IRQ <= 1'b1;
        @(posedge CLK);
        INT_IRQ <= 1'b0;
        #1;
        wait_rel(4);
        chk({3'h0, CPU_RELEASE, CPU_CLK_EN, STATE}, 8'h18);
        $display("wait test done");
    endtask
    task t_ahalt_on;
        enter(2'h1, 1'b1);
        chk({CPU_CLK_EN, PERIPH_CLK_EN, REG_EN, PAD_PATH_EN, PAD_PULLUP_EN, STATE}, 8'h2A);
        wait_rel(40);
        chk({7'h0, CPU_RELEASE & (n == 5)}, 8'h01);
        $display("active-halt regulator-on test done");
    endtask
    task t_ahalt_off;
        @(posedge CLK);
        XTAL_WAKE <= 1'b1;
        WAKE_INTERVAL <= 16'h0100;
        enter(2'h1, 1'b0);
        chk({CPU_CLK_EN, PERIPH_CLK_EN, REG_EN, PAD_PATH_EN, PAD_PULLUP_EN, STATE}, 8'h02);
        pulse_ext();
        chk({3'h0, CPU_CLK_EN, REG_EN, STATE}, 8'h0C);
        wait_rel(60);
        chk({7'h0, CPU_RELEASE & (n == 20)}, 8'h01);
        $display("active-halt regulator-off test done");
    endtask
    task t_halt;
        @(posedge CLK);
        XTAL_WAKE <= 1'b0;
        enter(2'h2, 1'b1);
        chk({CPU_CLK_EN, PERIPH_CLK_EN, REG_EN, PAD_PATH_EN, PAD_PULLUP_EN, STATE}, 8'h0B);
        @(posedge CLK);
        INT_IRQ <= 1'b1;
        repeat (300) @(posedge CLK);
        INT_IRQ <= 1'b0;
        #1;
        chk({5'h0, STATE}, 8'h03);
        @(posedge CLK);
        RESET_SRC <= 1'b1;
        @(posedge CLK);
        RESET_SRC <= 1'b0;
        #1;
        n = 0;
        while (SYS_RESET_REQ !== 1'b1 && n < 4) begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk({6'h0, SYS_RESET_REQ, CPU_RELEASE}, 8'h02);
        repeat (3) @(posedge CLK);
        #1;
        chk({5'h0, STATE}, 8'h00);
        chk(resume_cnt, 8'h03);
        enter(2'h3, 1'b0);
        chk({CPU_CLK_EN, PERIPH_CLK_EN, REG_EN, PAD_PATH_EN, POWER_KEEP, STATE}, 8'hF8);
        $display("halt test done");
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge CLK);
        RSTN <= 1'b1;
        t_wait();
        t_ahalt_on();
        t_ahalt_off();
        t_halt();
        summarize();
    end
endmodule
